/* File: logic/rscf_pkg.sv */
// Package for the reset sequencer and reset-cause capture block.
// Assumes a single 200 MHz pclk domain; used by rscf_top, the checker and the bench.
package rscf_pkg;
	// Clock rate in kHz
	localparam int CLK_KHZ = 200000;
	// Crystal settle time in microseconds, and its cycle count (least time, rounded up)
	localparam int SETTLE_US = 100;
	localparam int SETTLE_CYC = (SETTLE_US * CLK_KHZ + 999) / 1000;
	// Power-on delay default in microseconds (plain default, shortened in simulation)
	localparam int POR_US = 10;
	localparam int POR_CYC = (POR_US * CLK_KHZ + 999) / 1000;
	// Power-up timer default in milliseconds
	localparam int POWER_UP_DELAY_TIMER_MS = 16;
	localparam int POWER_UP_DELAY_TIMER_CYC = POWER_UP_DELAY_TIMER_MS * CLK_KHZ;
	// Oscillator start-up timer length in oscillator periods, counted on sampled edges
	localparam int OST_PERIODS = 1024;
	// Counter width
	localparam int CNT_W = 24;
	// Restart addresses
	localparam logic [23:0] RESET_VECTOR = 24'h00_0000;
	localparam logic [23:0] TRAP_VECTOR = 24'h00_0004;
	localparam logic [23:0] PC_STEP = 24'h00_0002;
	// APB register byte addresses
	localparam logic [11:0] ADDR_CAUSE = 12'h000;
	localparam logic [11:0] ADDR_OSC = 12'h004;
	localparam logic [11:0] ADDR_CONFIG = 12'h008;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h00C;
	localparam logic [11:0] ADDR_IRQ_CLR = 12'h010;
	localparam logic [11:0] ADDR_IRQ_EN = 12'h014;
	localparam logic [11:0] ADDR_PC = 12'h018;
	// reset_cause_reg bit positions
	localparam int BOR_BIT = 1;
	localparam int POR_BIT = 0;
	localparam int SLEEP_BIT = 3;
	localparam int IDLE_BIT = 2;
	localparam int WATCHDOG_TIMEOUT_FLAG_BIT = 4;
	localparam int SWR_BIT = 6;
	localparam int PIN_RESET_FLAG_BIT = 7;
	localparam int IOP_BIT = 14;
	localparam int TRAP_BIT = 15;
	localparam logic [15:0] CAUSE_RESET = 16'h0003;
	// oscillator_control_reg fields
	localparam int LOCK_BIT = 5;
	localparam int CUR_OSC_LSB = 12;
	// config register fields
	localparam int FOS_LSB = 0;
	localparam int FPR_LSB = 2;
	localparam int CFG_CLOCK_FAIL_MONITOR_BIT = 8;
	localparam int CFG_POWER_UP_DELAY_TIMER_BIT = 9;
	localparam int CFG_PLL_BIT = 10;
	localparam int CFG_XTAL_BIT = 11;
	localparam int CFG_OSCMODE_BIT = 12;
	localparam logic [15:0] CONFIG_RESET = 16'h0000;
	// Interrupt status bits
	localparam int IRQ_W = 4;
	localparam int IRQ_RELEASE = 0;
	localparam int IRQ_CLKFAIL = 1;
	localparam int IRQ_BOR = 2;
	localparam int IRQ_WAKE = 3;
	// Clock family encodings for the current-oscillator field
	localparam logic [1:0] OSC_FRC = 2'h0;
	// Sequencer states
	typedef enum logic [2:0] {RS_HOLD, RS_DELAY, RS_CLKWAIT, RS_RUN} rscf_state_t;
endpackage

/* File: logic/rscf_top.sv */
// Reset sequencer with reset-cause flags, clock-fail trap and restart address.
// Assumes an APB master on pclk; all event pins are asynchronous and synchronised here.
// What this block does
// RULE1: Clock monitor traps if clock unqualified after delays
// RULE2: Trap switches system clock to fast RC
// RULE3: No monitor, no timer: leave reset promptly
// RULE4: No monitor, no clock: stay frozen at vector
// RULE5: Brown-out pulses reset, picks clock from config
// RULE6: Brown-out starts start-up timer, holds clock
// RULE7: PLL in use: hold until lock bit 5
// RULE8: Power-on and power-up delays run together
// RULE9: Zero power-up timer with crystal adds settle
// RULE10: Brown-out sets brown-out flag bit 1
// RULE11: Brown-out detector works in sleep and idle
// RULE12: Resets restart at zero; power-on sets both
// RULE13: Pin, software, watchdog resets set own flags
// RULE14: Pin reset in sleep/idle sets mode flag
// RULE15: Wake-ups continue at PC+2, set sleep
// RULE16: Interrupt wake-up loads interrupt vector
// RULE17: Clock trap vectors to 4; traps set flags
// RULE18: Flags software-writable; unnamed flags kept
// RULE19: Reset held until all qualified; one update
`timescale 1ns/1ps
module rscf_top #(
	parameter int POR_CYCLES = rscf_pkg::POR_CYC, // Power-on delay in cycles
	parameter int POWER_UP_DELAY_TIMER_CYCLES = rscf_pkg::POWER_UP_DELAY_TIMER_CYC // Power-up timer in cycles
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Asynchronous active-low power-on reset
	input wire logic [11:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic brownout_n, // Brown-out detector output, low on brown-out
	input wire logic master_clear_pin_n, // Master clear pin, low resets
	input wire logic sw_reset_req, // Software reset request
	input wire logic wdt_timeout, // Watchdog timeout
	input wire logic trap_conflict, // Trap conflict event
	input wire logic illegal_op, // Illegal operation event
	input wire logic wake_irq, // Enabled interrupt wake request
	input wire logic [23:0] wake_vector, // Vector of the waking interrupt
	input wire logic in_sleep, // Core is in Sleep
	input wire logic in_idle, // Core is in Idle
	input wire logic [23:0] core_pc, // Current program counter
	input wire logic osc_running, // Oscillator activity seen
	input wire logic osc_tick, // Oscillator period tick
	input wire logic pll_lock, // PLL lock status
	output logic internal_reset, // Internal reset to the core, high holds
	output logic clk_gate_en, // System clock enabled to the core
	output logic [1:0] sys_clk_sel, // Selected clock family
	output logic restart_valid, // One-cycle pulse: restart_addr is to be loaded
	output logic [23:0] restart_addr, // Address to continue execution from
	output logic irq // Level interrupt
);
	import rscf_pkg::*;

	// Two-flop synchronisers for every asynchronous input; first stage read only by second
	localparam int NS = 12;
	logic [NS-1:0] sync1;
	logic [NS-1:0] sync2;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {~brownout_n, ~master_clear_pin_n, sw_reset_req, wdt_timeout,
				trap_conflict, illegal_op, wake_irq, in_sleep, in_idle,
				osc_running, osc_tick, pll_lock};
			sync2 <= sync1;
		end
	end
	logic bor_s, master_clear_pin_s, swr_s, wdt_s, trc_s, iop_s, wake_s, slp_s, idl_s, run_s, tick_s, lock_s;
	assign {bor_s, master_clear_pin_s, swr_s, wdt_s, trc_s, iop_s, wake_s, slp_s, idl_s,
		run_s, tick_s, lock_s} = sync2;

	// Previous levels for rising-edge detection; one cause update per event
	logic [6:0] prev; // Previous bor, master_clear_pin, swr, wdt, trc, iop, wake
	logic tick_prev; // Previous oscillator tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= '0;
			tick_prev <= 1'b0;
		end else begin
			prev <= {bor_s, master_clear_pin_s, swr_s, wdt_s, trc_s, iop_s, wake_s};
			tick_prev <= tick_s;
		end
	end
	// Brown-out is honoured in every mode, sleep and idle included
	logic bor_ev, master_clear_pin_ev, swr_ev, wdt_ev, trc_ev, iop_ev, wake_ev, tick_ev;
	assign bor_ev = bor_s & ~prev[6]; // [RULE11]
	assign master_clear_pin_ev = master_clear_pin_s & ~prev[5];
	assign swr_ev = swr_s & ~prev[4];
	assign wdt_ev = wdt_s & ~prev[3];
	assign trc_ev = trc_s & ~prev[2];
	assign iop_ev = iop_s & ~prev[1];
	assign wake_ev = wake_s & ~prev[0];
	assign tick_ev = tick_s & ~tick_prev;
	// Watchdog in sleep is a wake-up, otherwise a reset
	logic wdt_wake, wdt_rst, any_reset;
	assign wdt_wake = wdt_ev & slp_s;
	assign wdt_rst = wdt_ev & ~slp_s;
	assign any_reset = bor_ev | master_clear_pin_ev | swr_ev | wdt_rst | trc_ev | iop_ev;

	// Registers
	logic [15:0] cause; // reset_cause_reg
	logic [15:0] config_reg; // Clock configuration
	logic [IRQ_W-1:0] irq_stat; // Sticky interrupt status
	logic [IRQ_W-1:0] irq_en; // Interrupt enables
	logic [1:0] cur_osc; // Current clock family
	logic wr_acc, rd_acc, hit;
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign hit = paddr inside {ADDR_CAUSE, ADDR_OSC, ADDR_CONFIG, ADDR_IRQ_STAT,
		ADDR_IRQ_CLR, ADDR_IRQ_EN, ADDR_PC};
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// Sequencer state and delay counters
	rscf_state_t state;
	logic [CNT_W-1:0] por_cnt; // Power-on delay count
	logic [CNT_W-1:0] power_up_delay_timer_cnt; // Power-up or settle count
	logic [10:0] ost_cnt; // Oscillator start-up periods seen
	logic ost_done, needs_ost, clock_fail_monitor_en, power_up_delay_timer_en, pll_used, xtal, delays_done, clk_ok;
	logic after_bor; // Last reset came from brown-out or power-on
	assign clock_fail_monitor_en = config_reg[CFG_CLOCK_FAIL_MONITOR_BIT];
	assign power_up_delay_timer_en = config_reg[CFG_POWER_UP_DELAY_TIMER_BIT];
	assign pll_used = config_reg[CFG_PLL_BIT];
	assign xtal = config_reg[CFG_XTAL_BIT];
	// Oscillator start-up timer only applies when an oscillator mode is chosen
	assign needs_ost = config_reg[CFG_OSCMODE_BIT] & after_bor; // [RULE6]
	assign ost_done = (ost_cnt == 11'(OST_PERIODS)) | ~needs_ost;
	assign delays_done = (por_cnt == '0) & (power_up_delay_timer_cnt == '0); // [RULE8]
	// Clock qualified: running, start-up timer done, PLL locked if used
	assign clk_ok = run_s & ost_done & (lock_s | ~pll_used); // [RULE7]

	// Sequencer: hold, concurrent delays, then clock qualification
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= RS_HOLD;
			por_cnt <= '0;
			power_up_delay_timer_cnt <= '0;
			ost_cnt <= '0;
			after_bor <= 1'b1;
		end else if (any_reset) begin
			// Every reset source restarts the whole sequence
			state <= RS_DELAY; // [RULE5]
			por_cnt <= CNT_W'(POR_CYCLES);
			// Zero power-up timer with crystal still waits for settling
			if (power_up_delay_timer_en)
				power_up_delay_timer_cnt <= CNT_W'(POWER_UP_DELAY_TIMER_CYCLES); // [RULE8]
			else if (xtal)
				power_up_delay_timer_cnt <= CNT_W'(SETTLE_CYC); // [RULE9]
			else
				power_up_delay_timer_cnt <= '0;
			ost_cnt <= '0;
			after_bor <= bor_ev; // [RULE6]
		end else begin
			if (por_cnt != '0)
				por_cnt <= por_cnt - 1'b1;
			if (power_up_delay_timer_cnt != '0)
				power_up_delay_timer_cnt <= power_up_delay_timer_cnt - 1'b1;
			if (tick_ev && ost_cnt != 11'(OST_PERIODS))
				ost_cnt <= ost_cnt + 1'b1;
			case (state)
				RS_HOLD: begin
					// Power-on: start the concurrent delays
					state <= RS_DELAY;
					por_cnt <= CNT_W'(POR_CYCLES);
					power_up_delay_timer_cnt <= power_up_delay_timer_en ? CNT_W'(POWER_UP_DELAY_TIMER_CYCLES) : '0;
				end
				RS_DELAY: begin
					// Without monitor and timer this is immediate after power-on delay
					if (delays_done)
						state <= RS_CLKWAIT; // [RULE3]
				end
				RS_CLKWAIT: begin
					// With the monitor on, an unqualified clock traps to fast RC
					if (clk_ok || clock_fail_monitor_en)
						state <= RS_RUN; // [RULE1] [RULE4]
				end
				RS_RUN: begin
					state <= RS_RUN;
				end
				default: state <= RS_HOLD;
			endcase
		end
	end
	logic trap_fire; // Clock-fail trap pulse
	assign trap_fire = !any_reset && state == RS_CLKWAIT && clock_fail_monitor_en && !clk_ok; // [RULE1]
	logic release_ev; // Reset release pulse
	assign release_ev = !any_reset && state == RS_CLKWAIT && (clk_ok || clock_fail_monitor_en); // [RULE19]

	// Reset held from source until qualified, frozen if no clock and no monitor
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			internal_reset <= 1'b1;
			clk_gate_en <= 1'b0;
		end else begin
			internal_reset <= (state != RS_RUN) & ~release_ev | any_reset; // [RULE19] [RULE4]
			clk_gate_en <= (state == RS_RUN | release_ev) & ~any_reset; // [RULE6] [RULE7]
		end
	end

	// Clock family: configured on reset, forced to fast RC on trap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cur_osc <= OSC_FRC;
		else if (trap_fire)
			cur_osc <= OSC_FRC; // [RULE2]
		else if (any_reset || state == RS_HOLD)
			cur_osc <= config_reg[FOS_LSB +: 2]; // [RULE5]
		else if (wr_acc && paddr == ADDR_OSC)
			cur_osc <= pwdata[CUR_OSC_LSB +: 2];
	end
	assign sys_clk_sel = cur_osc;

	// Restart address and pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			restart_valid <= 1'b0;
			restart_addr <= RESET_VECTOR;
		end else begin
			restart_valid <= 1'b0;
			if (trap_fire) begin
				restart_valid <= 1'b1;
				restart_addr <= TRAP_VECTOR; // [RULE17]
			end else if (release_ev) begin
				restart_valid <= 1'b1;
				restart_addr <= RESET_VECTOR; // [RULE12]
			end else if (state == RS_RUN && slp_s && (wake_ev || wdt_wake)) begin
				restart_valid <= 1'b1;
				// Interrupt wake-up enters its vector, watchdog continues
				restart_addr <= wake_ev ? wake_vector : core_pc + PC_STEP; // [RULE15] [RULE16]
			end
		end
	end

	// Reset-cause flags: each event names its flags, others are kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause <= CAUSE_RESET; // [RULE12]
		end else begin
			// Software writes first so a same-cycle event wins
			if (wr_acc && paddr == ADDR_CAUSE)
				cause <= pwdata[15:0]; // [RULE18]
			if (bor_ev) begin
				cause[BOR_BIT] <= 1'b1; // [RULE10]
				cause[POR_BIT] <= 1'b0; // [RULE12]
			end else if (master_clear_pin_ev) begin
				cause[PIN_RESET_FLAG_BIT] <= 1'b1; // [RULE13] [RULE14]
				cause[WATCHDOG_TIMEOUT_FLAG_BIT] <= 1'b0;
				cause[SLEEP_BIT] <= slp_s;
				cause[IDLE_BIT] <= idl_s & ~slp_s;
				if (!slp_s && !idl_s)
					cause[SWR_BIT] <= 1'b0;
			end else if (swr_ev) begin
				cause[SWR_BIT] <= 1'b1; // [RULE13]
				cause[PIN_RESET_FLAG_BIT] <= 1'b0;
				cause[WATCHDOG_TIMEOUT_FLAG_BIT] <= 1'b0;
				cause[SLEEP_BIT] <= 1'b0;
				cause[IDLE_BIT] <= 1'b0;
			end else if (wdt_rst) begin
				cause[WATCHDOG_TIMEOUT_FLAG_BIT] <= 1'b1; // [RULE13]
				cause[PIN_RESET_FLAG_BIT] <= 1'b0;
				cause[SWR_BIT] <= 1'b0;
				cause[SLEEP_BIT] <= 1'b0;
				cause[IDLE_BIT] <= 1'b0;
			end else if (wdt_wake) begin
				cause[WATCHDOG_TIMEOUT_FLAG_BIT] <= 1'b1; // [RULE15]
				cause[SLEEP_BIT] <= 1'b1;
			end else if (trc_ev) begin
				cause[TRAP_BIT] <= 1'b1; // [RULE17]
			end else if (iop_ev) begin
				cause[IOP_BIT] <= 1'b1; // [RULE17]
			end else if (wake_ev && slp_s) begin
				cause[SLEEP_BIT] <= 1'b1; // [RULE15]
			end
		end
	end

	// Configuration register, kept across internal resets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			config_reg <= CONFIG_RESET;
		else if (wr_acc && paddr == ADDR_CONFIG)
			config_reg <= pwdata[15:0];
	end

	// Interrupts: sticky status, write-one clear, set wins
	logic [IRQ_W-1:0] irq_set;
	assign irq_set = {wake_ev & slp_s, bor_ev, trap_fire, release_ev};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
			irq_en <= '0;
		end else begin
			if (wr_acc && paddr == ADDR_IRQ_CLR)
				irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_set;
			else
				irq_stat <= irq_stat | irq_set;
			if (wr_acc && paddr == ADDR_IRQ_EN)
				irq_en <= pwdata[IRQ_W-1:0];
		end
	end
	assign irq = |(irq_stat & irq_en);

	// Read mux, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= '0;
		else if (psel && !penable && !pwrite) begin
			case (paddr)
				ADDR_CAUSE: prdata <= {16'h0000, cause};
				ADDR_OSC: prdata <= 32'({cur_osc, 12'h000} | (16'(lock_s) << LOCK_BIT));
				ADDR_CONFIG: prdata <= {16'h0000, config_reg};
				ADDR_IRQ_STAT: prdata <= 32'(irq_stat);
				ADDR_IRQ_EN: prdata <= 32'(irq_en);
				ADDR_PC: prdata <= {8'h00, restart_addr};
				default: prdata <= '0;
			endcase
		end
	end
	logic unused_rd;
	assign unused_rd = rd_acc;
endmodule // rscf_top

/* File: testbench/rscf_sva.sv */
// Port-level assertions for the reset sequencer and reset-cause block.
// Assumes one pclk domain; bound to rscf_top from the testbench top file.
`timescale 1ns/1ps
module rscf_sva
	import rscf_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic [11:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic brownout_n, // Brown-out, low active
	input wire logic master_clear_pin_n, // Pin reset, low active
	input wire logic sw_reset_req, // Software reset
	input wire logic trap_conflict, // Trap conflict
	input wire logic internal_reset, // Core reset
	input wire logic restart_valid, // Restart strobe
	input wire logic [23:0] restart_addr, // Restart address
	input wire logic [1:0] sys_clk_sel // Clock family
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Two sync stages plus a register: eight edges leave some margin
	sequence s_held;
		##[1:8] internal_reset;
	endsequence
	property p_bor_hold; $fell(brownout_n) |-> s_held; endproperty
	a_bor_hold: assert property (p_bor_hold) else $error("brown-out left core running");
	property p_pin_hold; $fell(master_clear_pin_n) |-> s_held; endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pin reset left core running");
	property p_swr_hold; $rose(sw_reset_req) |-> s_held; endproperty
	a_swr_hold: assert property (p_swr_hold) else $error("software reset ignored");
	property p_trap_hold; $rose(trap_conflict) |-> s_held; endproperty
	a_trap_hold: assert property (p_trap_hold) else $error("trap conflict ignored");
	// A restart strobe lasts one cycle so the core loads the address once
	property p_rv_pulse; restart_valid |=> !restart_valid; endproperty
	a_rv_pulse: assert property (p_rv_pulse) else $error("restart strobe too long");
	property p_trap_frc;
		restart_valid && restart_addr == TRAP_VECTOR |-> ##[0:2] (sys_clk_sel == OSC_FRC);
	endproperty
	a_trap_frc: assert property (p_trap_frc) else $error("trap kept slow clock");
	// Zero wait states on every access
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("access not answered");
	property p_unmapped; psel && penable && paddr > ADDR_PC |-> pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
	property p_err_phase; !penable |-> !pslverr; endproperty
	a_err_phase: assert property (p_err_phase) else $error("error outside access phase");
endmodule // rscf_sva

/* File: testbench/rscf_tb_top.sv */
// Self-checking bench for rscf_top: APB tasks and reset-event sequences.
// Assumes rscf_pkg and the checker are compiled first; short delays used.
`timescale 1ns/1ps
module rscf_tb_top;
	import rscf_pkg::*;
	logic pclk = 0; // Clock
	logic presetn = 0; // Reset, active low
	logic psel = 0, penable = 0, pwrite = 0; // APB controls
	logic [11:0] paddr = '0; // APB address
	logic [31:0] pwdata = '0, prdata, r; // APB data and last read
	logic pready, pslverr, err; // APB answer and last error
	logic [6:0] ev = '0; // Event strobes, high active
	logic in_sleep = 0, in_idle = 0, osc_running = 1, osc_tick = 0, pll_lock = 1; // Core status
	logic [23:0] wake_vector = 24'h00_0040, core_pc = 24'h00_0100, restart_addr; // Addresses
	logic internal_reset, clk_gate_en, restart_valid, irq; // Sequencer outputs
	logic [1:0] sys_clk_sel; // Clock family
	int error_cnt = 0, n_tests = 0, cyc = 0, cnt; // Counters
	int kk[11] = '{5, 0, 1, 6, 2, 3, 1, 4, 5, 5, 6}; // Event per row
	logic [23:0] va[11] = '{0, 0, 0, 0, 0, 0, 24'h00_0102, 24'h00_0040, 0, 0, 0}; // Restart
	logic [31:0] ca[11] = '{32'h0000_0080, 32'h0000_0040, 32'h0000_0010, 32'h0000_0012,
		32'h0000_8012, 32'h0000_C012, 32'h0000_C01A, 32'h0000_C01A, 32'h0000_C08A,
		32'h0000_0084, 32'h0000_0086}; // Flags after row
	always #2.5 pclk = ~pclk;
	// Oscillator ticks at half the bus rate
	always @(posedge pclk) osc_tick <= ~osc_tick;
	// Hang guard: the run needs about 25000 cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			results();
		end
	end
	rscf_top #(.POR_CYCLES(20), .POWER_UP_DELAY_TIMER_CYCLES(50)) i_rscf_top (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .brownout_n(~ev[6]),
		.master_clear_pin_n(~ev[5]), .sw_reset_req(ev[0]), .wdt_timeout(ev[1]),
		.trap_conflict(ev[2]), .illegal_op(ev[3]), .wake_irq(ev[4]), .wake_vector(wake_vector),
		.in_sleep(in_sleep), .in_idle(in_idle), .core_pc(core_pc), .osc_running(osc_running),
		.osc_tick(osc_tick), .pll_lock(pll_lock), .internal_reset(internal_reset),
		.clk_gate_en(clk_gate_en), .sys_clk_sel(sys_clk_sel), .restart_valid(restart_valid),
		.restart_addr(restart_addr), .irq(irq));
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; the request is held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, '0);
		chk(r, exp);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// Idle cycles first so mode levels settle through the synchronisers
	task automatic fire(input int k);
		repeat (3) @(posedge pclk);
		ev[k] <= 1'b1;
		@(posedge pclk);
		ev[k] <= 1'b0;
	endtask
	// Wait for the restart strobe; cnt gives the cycles taken
	task automatic wait_rs(input logic [23:0] a);
		cnt = 0;
		do begin
			@(posedge pclk);
			cnt++;
		end while (restart_valid !== 1'b1 && cnt < 30000);
		// A wait that ran out must not pass on a stale address
		chk({31'b0, restart_valid}, 32'h0000_0001);
		chk({8'h00, restart_addr}, {8'h00, a});
	endtask
	task automatic timed(input logic [31:0] cfg, input int k, input int lo, input int hi);
		wr(ADDR_CONFIG, cfg);
		fire(k);
		wait_rs(RESET_VECTOR);
		chk({31'b0, cnt > lo && cnt < hi}, 32'h0000_0001);
	endtask
	// Reset must stay held while the clock is unqualified
	task automatic stall(input logic [31:0] cfg);
		wr(ADDR_CONFIG, cfg);
		fire(5);
		repeat (300) @(posedge pclk);
		chk({31'b0, internal_reset}, 32'h0000_0001);
		chk({31'b0, clk_gate_en}, 32'h0000_0000);
		pll_lock <= 1'b1;
		osc_running <= 1'b1;
		wait_rs(RESET_VECTOR);
		chk({31'b0, clk_gate_en}, 32'h0000_0001);
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		wait_rs(RESET_VECTOR);
		rd(ADDR_CAUSE, 32'h0000_0003);
		rd(12'h020, 32'h0000_0000);
		chk({31'b0, err}, 32'h0000_0001);
		// Release event raises the line once enabled, clearing drops it
		wr(ADDR_IRQ_EN, 32'h0000_000F);
		@(posedge pclk);
		chk({31'b0, irq}, 32'h0000_0001);
		wr(ADDR_IRQ_CLR, 32'h0000_000F);
		wr(ADDR_IRQ_EN, 32'h0000_0000);
		@(posedge pclk);
		chk({31'b0, irq}, 32'h0000_0000);
		wr(ADDR_CAUSE, 32'h0000_0000);
		rd(ADDR_CAUSE, 32'h0000_0000);
		// Each row: mode, event, restart address, flags kept or changed
		for (int i = 0; i < 11; i++) begin
			in_sleep <= (i > 5 && i < 9);
			in_idle <= (i > 8);
			if (i == 9) wr(ADDR_CAUSE, 32'h0000_0000);
			fire(kk[i]);
			wait_rs(va[i]);
			if (i == 0) chk({31'b0, cnt < 40}, 32'h0000_0001);
			rd(ADDR_CAUSE, ca[i]);
		end
		in_idle <= 1'b0;
		timed(32'h0000_0200, 5, 42, 66);
		timed(32'h0000_0800, 5, SETTLE_CYC - 8, SETTLE_CYC + 40);
		timed(32'h0000_1002, 6, OST_PERIODS - 8, 4 * OST_PERIODS);
		repeat (2) @(posedge pclk);
		chk({30'b0, sys_clk_sel}, 32'h0000_0002);
		pll_lock <= 1'b0;
		stall(32'h0000_0400);
		osc_running <= 1'b0;
		stall(32'h0000_0000);
		// Monitor on and no clock: trap, fast RC, flags untouched
		wr(ADDR_IRQ_EN, 32'h0000_0002);
		wr(ADDR_CONFIG, 32'h0000_0100);
		osc_running <= 1'b0;
		fire(5);
		wait_rs(TRAP_VECTOR);
		repeat (2) @(posedge pclk);
		chk({30'b0, sys_clk_sel}, {30'b0, OSC_FRC});
		chk({31'b0, irq}, 32'h0000_0001);
		rd(ADDR_CAUSE, 32'h0000_0082);
		osc_running <= 1'b1;
		results();
	end
endmodule // rscf_tb_top
bind rscf_top rscf_sva i_rscf_sva (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .brownout_n(brownout_n),
	.master_clear_pin_n(master_clear_pin_n), .sw_reset_req(sw_reset_req),
	.trap_conflict(trap_conflict), .internal_reset(internal_reset),
	.restart_valid(restart_valid), .restart_addr(restart_addr), .sys_clk_sel(sys_clk_sel));
